// ### pse_event_pkg.sv
/*
 * Shared constants and carrier types for the event collection and
 * interrupt logic of the power sourcing controller.
 * Assumes a command-code register port driven by the serial front end.
 */
package pse_event_pkg;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_INTERRUPT_SUMMARY = 8'h00;
    localparam logic [7:0] CMD_INTERRUPT_MASK = 8'h01;
    localparam logic [7:0] CMD_POWER_EVENT_PEEK = 8'h02;
    localparam logic [7:0] CMD_POWER_EVENT_CLEAR_READ = 8'h03;
    localparam logic [7:0] CMD_DETECTION_EVENT_PEEK = 8'h04;
    localparam logic [7:0] CMD_DETECTION_EVENT_CLEAR_READ = 8'h05;

    // ----------------------------------------------------------------
    // Summary and mask bit positions
    // ----------------------------------------------------------------
    localparam int BIT_SUPPLY_FAULT = 7;
    localparam int BIT_START_FAULT = 6;
    localparam int BIT_OVERCURRENT_FAULT = 5;
    localparam int BIT_CLASS_CYCLE = 4;
    localparam int BIT_DETECT_CYCLE = 3;
    localparam int BIT_DISCONNECT = 2;
    localparam int BIT_POWER_GOOD = 1;
    localparam int BIT_POWER_ENABLE = 0;

    localparam int CHANNELS = 4;

    localparam logic [7:0] MASK_RESET = 8'h80;
    localparam logic [7:0] SUMMARY_RESET = 8'h00;
    localparam logic [7:0] EVENT_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Summary bits that latch here rather than follow this block's registers.
    localparam logic [7:0] STICKY_SUMMARY = 8'hE4;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] power_good_change_ch;
        logic [3:0] power_enable_change_ch;
    } power_event_t;

    typedef struct packed {
        logic [3:0] class_cycle_ch;
        logic [3:0] detect_cycle_ch;
    } detection_event_t;

    // Event pulses from the channel state machines, one bit per channel.
    typedef struct packed {
        logic [3:0] power_good_change;
        logic [3:0] power_enable_change;
        logic [3:0] class_cycle;
        logic [3:0] class_result_change;
        logic [3:0] detect_cycle;
        logic [3:0] detect_result_change;
        logic [3:0] channel_off;
    } channel_events_t;

    // Summary sources held by event registers outside this block.
    typedef struct packed {
        logic supply_fault;
        logic start_fault;
        logic overcurrent_fault;
        logic disconnect;
    } other_sources_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] code;
        logic [7:0] wdata;
    } reg_request_t;

endpackage : pse_event_pkg

// ### irq_gate.sv
/*
 * Masking stage that turns the summary byte into the active-low
 * interrupt pin level.
 * Assumes summary and mask come from flip-flops on the same clock.
 */
`timescale 1ns/10ps
module irq_gate (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] summary,
    input wire logic [7:0] interrupt_mask,
    input wire logic global_irq_enable,
    output logic irq_n
);
    import pse_event_pkg::*;

    // ----------------------------------------------------------------
    // Pin driver
    // ----------------------------------------------------------------
    // The pin is registered so it never glitches on a decode hazard.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else if (clk_en) begin
            irq_n <= ~(global_irq_enable && |(summary & interrupt_mask));
        end
    end

endmodule : irq_gate

// ### pse_event_interrupt_logic.sv
/*
 * Event registers, summary byte, mask register and interrupt pin of a
 * four-channel slice of the power sourcing controller.
 * The summary byte reads at code 00h; its sticky fault bits stand for
 * event registers kept outside this block and drop only on a summary reset.
 * Assumes the serial front end presents one-cycle read and write strobes
 * with a command code on clk, and the channel logic gives event pulses.
 * The configuration levels (global enable, change modes) come from a
 * general mask register on the same clock, so they are not resynchronised.
 */
//
// What this block does
// - Summary bit 0 is OR of the four power-enable change bits.
// - Mask at code 01h is read/write; zero bit blocks its category.
// - Summary bits track events regardless of mask contents.
// - Interrupt needs global enable set besides the category mask.
// - Mask bit order matches summary: supply fault at 7 down to power enable 0.
// - Mask resets with supply fault bit 1, others 0.
// - Power events read at 02h unchanged, at 03h cleared.
// - Power event bits 7-4 power good, 3-0 power enable changes, reset 0.
// - Detection events read at 04h unchanged, at 05h cleared.
// - A channel's detection bits clear when that channel turns off.
// - Clear-on-read of the power or detection event register releases the interrupt if no other unmasked summary bit is set; sticky bits need a summary reset.
// - Detection bits flag cycles, or result changes when change mode set.
// - Own summary bits clear on event register clear-read (03h, 05h) or summary reset request; sticky bits on summary reset only.
// - Interrupt asserts when a summary bit, its mask and global enable are set.
`timescale 1ns/10ps
module pse_event_interrupt_logic (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input pse_event_pkg::reg_request_t req,
    output logic [7:0] rdata,
    input pse_event_pkg::channel_events_t events,
    input pse_event_pkg::other_sources_t other_sources,
    input wire logic global_irq_enable,
    input wire logic class_change_mode,
    input wire logic detect_change_mode,
    input wire logic summary_reset,
    output logic irq_n
);
    import pse_event_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic hit(input reg_request_t r, input logic [7:0] code);
        hit = r.rd && (r.code == code);
    endfunction : hit

    logic clear_power;
    logic clear_detect;
    logic drop_power;
    logic drop_detect;
    logic write_mask;
    assign clear_power = hit(req, CMD_POWER_EVENT_CLEAR_READ);
    assign clear_detect = hit(req, CMD_DETECTION_EVENT_CLEAR_READ);
    // A summary reset also empties this block's own event registers: their
    // summary bits are live ORs, so clearing only the summary would not stick.
    assign drop_power = clear_power | summary_reset;
    assign drop_detect = clear_detect | summary_reset;
    // Writes to any other code are dropped, including the read-only aliases.
    assign write_mask = req.wr && (req.code == CMD_INTERRUPT_MASK);

    // ----------------------------------------------------------------
    // Mask register
    // ----------------------------------------------------------------
    logic [7:0] interrupt_mask;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_mask <= MASK_RESET;
        end else if (clk_en && write_mask) begin
            interrupt_mask <= req.wdata;
        end
    end

    // ----------------------------------------------------------------
    // Event registers
    // ----------------------------------------------------------------
    power_event_t power_event;
    detection_event_t detection_event;
    logic [3:0] class_src;
    logic [3:0] detect_src;

    // One channel nibble of an event register. A new event beats a clear in
    // the same cycle, so an event that lands during the host's read survives.
    function automatic logic [3:0] next_nibble(
        input logic [3:0] held,
        input logic drop,
        input logic [3:0] off,
        input logic [3:0] fresh
    );
        logic [3:0] kept;
        kept = drop ? '0 : held;
        next_nibble = (kept & ~off) | fresh;
    endfunction : next_nibble

    // Selected source per mode
    assign class_src = class_change_mode ? events.class_result_change : events.class_cycle;
    assign detect_src = detect_change_mode ? events.detect_result_change : events.detect_cycle;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_event <= EVENT_RESET;
        end else if (clk_en) begin
            power_event.power_good_change_ch <= next_nibble(power_event.power_good_change_ch,
                drop_power, '0, events.power_good_change);
            power_event.power_enable_change_ch <= next_nibble(power_event.power_enable_change_ch,
                drop_power, '0, events.power_enable_change);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            detection_event <= EVENT_RESET;
        end else if (clk_en) begin
            detection_event.class_cycle_ch <= next_nibble(detection_event.class_cycle_ch,
                drop_detect, events.channel_off, class_src);
            detection_event.detect_cycle_ch <= next_nibble(detection_event.detect_cycle_ch,
                drop_detect, events.channel_off, detect_src);
        end
    end

    // ----------------------------------------------------------------
    // Summary byte
    // ----------------------------------------------------------------
    // Own-register categories follow their event registers directly, so a
    // clear-on-read drops the summary bit, and the pin if no other unmasked bit is set.
    logic [7:0] summary;
    logic [7:0] summary_flags;
    logic [7:0] next_summary_flags;

    always_comb begin
        next_summary_flags = summary_flags;
        if (summary_reset) begin
            next_summary_flags = SUMMARY_RESET;
        end
        next_summary_flags[BIT_SUPPLY_FAULT] = next_summary_flags[BIT_SUPPLY_FAULT]
            | other_sources.supply_fault;
        next_summary_flags[BIT_START_FAULT] = next_summary_flags[BIT_START_FAULT]
            | other_sources.start_fault;
        next_summary_flags[BIT_OVERCURRENT_FAULT] = next_summary_flags[BIT_OVERCURRENT_FAULT]
            | other_sources.overcurrent_fault;
        next_summary_flags[BIT_DISCONNECT] = next_summary_flags[BIT_DISCONNECT]
            | other_sources.disconnect;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            summary_flags <= SUMMARY_RESET;
        end else if (clk_en) begin
            summary_flags <= next_summary_flags;
        end
    end

    // Sticky bits stand for registers kept outside; only a summary reset clears them.
    always_comb begin
        summary = summary_flags & STICKY_SUMMARY;
        summary[BIT_CLASS_CYCLE] = |detection_event.class_cycle_ch;
        summary[BIT_DETECT_CYCLE] = |detection_event.detect_cycle_ch;
        summary[BIT_POWER_GOOD] = |power_event.power_good_change_ch;
        summary[BIT_POWER_ENABLE] = |power_event.power_enable_change_ch;
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        unique case (req.code)
            CMD_INTERRUPT_SUMMARY: next_rdata = summary;
            CMD_INTERRUPT_MASK: next_rdata = interrupt_mask;
            CMD_POWER_EVENT_PEEK,
            CMD_POWER_EVENT_CLEAR_READ: next_rdata = power_event;
            CMD_DETECTION_EVENT_PEEK,
            CMD_DETECTION_EVENT_CLEAR_READ: next_rdata = detection_event;
            default: next_rdata = READ_ZERO;
        endcase
    end

    // The byte is captured on the taken read, so it stands until the next one
    // even though the register behind it may have been cleared by that read.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= READ_ZERO;
        end else if (clk_en && req.rd) begin
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt pin
    // ----------------------------------------------------------------
    irq_gate u_irq_gate (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .summary(summary),
        .interrupt_mask(interrupt_mask),
        .global_irq_enable(global_irq_enable),
        .irq_n(irq_n)
    );

endmodule : pse_event_interrupt_logic

// ### host_model.sv
/* Host side of the command port, issuing one-cycle read and write strobes.
   Assumes the block takes a strobe on the rising edge of clk. */
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    output pse_event_pkg::reg_request_t req,
    input wire logic [7:0] rdata
);
    import pse_event_pkg::*;
    initial req = '0;
    // ------------------------------------------------------------
    // Access task
    // ------------------------------------------------------------
    // The strobe and its code stay put until the taking edge has passed.
    task automatic access(input logic rd, input logic [7:0] code, input logic [7:0] wdata,
        output logic [7:0] data);
        @(posedge clk);
        req <= '{rd: rd, wr: !rd, code: code, wdata: wdata};
        @(posedge clk);
        req <= '0;
        #1 data = rdata;
    endtask : access
endmodule : host_model

// ### pse_event_properties.sv
/* Checker for the event and interrupt block, bound to its top module.
   Assumes clk_en stays high and strobes last one cycle. */
`timescale 1ns/10ps
module pse_event_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input pse_event_pkg::reg_request_t req,
    input wire logic [7:0] rdata,
    input pse_event_pkg::channel_events_t events,
    input wire logic global_irq_enable,
    input wire logic irq_n
);
    import pse_event_pkg::*;
    logic [7:0] mask_m;
    logic pw_q;
    logic det_q;
    assign pw_q = {events.power_good_change, events.power_enable_change} == 8'h00;
    assign det_q = {events.class_cycle, events.class_result_change, events.detect_cycle,
        events.detect_result_change} == 16'h0000;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // The mask is mirrored here because only the pins are visible.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_m <= MASK_RESET;
        end else if (clk_en && req.wr && req.code == CMD_INTERRUPT_MASK) begin
            mask_m <= req.wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    power_on_a: assert property ($rose(reset_n) |-> irq_n [*2])
        else $error("irq active after reset");
    gate_off_a: assert property ((!global_irq_enable) [*3] |-> irq_n)
        else $error("irq active with enable off");
    mask_block_a: assert property ((mask_m == 8'h00) [*3] |-> irq_n)
        else $error("irq active with all masked");
    enable_irq_a: assert property (events.power_enable_change != 4'h0 && mask_m[0] &&
        global_irq_enable ##1 mask_m[0] && global_irq_enable && !req.wr
        |=> !global_irq_enable || !irq_n) else $error("irq missed power enable event");
    mask_read_a: assert property (clk_en && req.rd && req.code == CMD_INTERRUPT_MASK
        |=> rdata == $past(mask_m)) else $error("mask read wrong");
    unmapped_a: assert property (clk_en && req.rd && req.code > 8'h05
        |=> rdata == READ_ZERO) else $error("unmapped read not zero");
    power_clear_a: assert property (req.rd && req.code == CMD_POWER_EVENT_CLEAR_READ &&
        pw_q ##1 pw_q ##1 pw_q && req.rd && req.code == CMD_POWER_EVENT_PEEK
        |=> rdata == READ_ZERO) else $error("power events kept after clear");
    det_clear_a: assert property (req.rd && req.code == CMD_DETECTION_EVENT_CLEAR_READ &&
        det_q ##1 det_q ##1 det_q && req.rd && req.code == CMD_DETECTION_EVENT_PEEK
        |=> rdata == READ_ZERO) else $error("detection events kept after clear");
    irq_release_a: assert property (req.rd && req.code == CMD_POWER_EVENT_CLEAR_READ &&
        mask_m[7:2] == 6'h00 && pw_q && !req.wr ##1 pw_q && !req.wr |=> irq_n)
        else $error("irq held after clear");
    cover property (req.rd && req.code == CMD_POWER_EVENT_CLEAR_READ);
    cover property (!irq_n);
    cover property (req.wr && req.code == CMD_INTERRUPT_MASK);
endmodule : pse_event_checker
bind pse_event_interrupt_logic pse_event_checker chk (.clk, .reset_n, .clk_en, .req, .rdata,
    .events, .global_irq_enable, .irq_n);

// ### tb_top.sv
/* Self-checking bench for the event and interrupt block.
   Assumes host_model and the bound checker are compiled with it. */
`timescale 1ns/10ps
module tb_top;
    import pse_event_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic global_irq_enable = 1'b0;
    logic class_change_mode = 1'b0;
    logic detect_change_mode = 1'b0;
    logic summary_reset = 1'b0;
    channel_events_t events = '0;
    other_sources_t other_sources = '0;
    reg_request_t req;
    logic [7:0] rdata;
    logic irq_n;
    logic [7:0] d;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    host_model host (.clk(clk), .req(req), .rdata(rdata));
    pse_event_interrupt_logic dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .req(req),
        .rdata(rdata), .events(events), .other_sources(other_sources),
        .global_irq_enable(global_irq_enable), .class_change_mode(class_change_mode),
        .detect_change_mode(detect_change_mode), .summary_reset(summary_reset), .irq_n(irq_n));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        host.access(1'b1, code, 8'h00, d);
        chk(d, exp);
    endtask : rd
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        host.access(1'b0, code, data, d);
    endtask : wr
    // Waits three edges so the pin has followed the summary byte.
    task automatic pulse(input channel_events_t e, input other_sources_t o);
        @(posedge clk);
        events <= e;
        other_sources <= o;
        @(posedge clk);
        events <= '0;
        other_sources <= '0;
        repeat (3) @(posedge clk);
        #1;
    endtask : pulse
    task automatic reset_summary;
        @(posedge clk);
        summary_reset <= 1'b1;
        @(posedge clk);
        summary_reset <= 1'b0;
    endtask : reset_summary
    task automatic t_power;
        channel_events_t e;
        e = '0;
        e.power_enable_change = 4'h4;
        e.power_good_change = 4'h1;
        rd(CMD_INTERRUPT_MASK, MASK_RESET);
        rd(8'h07, READ_ZERO);
        chk({7'h00, irq_n}, 8'h01);
        wr(CMD_INTERRUPT_MASK, 8'h03);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        pulse(e, '0);
        chk({7'h00, irq_n}, 8'h00);
        rd(CMD_INTERRUPT_SUMMARY, 8'h03);
        rd(CMD_POWER_EVENT_PEEK, 8'h14);
        rd(CMD_POWER_EVENT_CLEAR_READ, 8'h14);
        rd(CMD_POWER_EVENT_PEEK, READ_ZERO);
        chk({7'h00, irq_n}, 8'h01);
        $display("power test done");
    endtask : t_power
    task automatic t_mask;
        channel_events_t e;
        e = '0;
        e.detect_cycle = 4'h2;
        wr(CMD_INTERRUPT_MASK, 8'h00);
        pulse(e, '0);
        chk({7'h00, irq_n}, 8'h01);
        rd(CMD_INTERRUPT_SUMMARY, 8'h08);
        @(posedge clk);
        global_irq_enable <= 1'b0;
        wr(CMD_INTERRUPT_MASK, 8'h08);
        pulse('0, '0);
        chk({7'h00, irq_n}, 8'h01);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        pulse('0, '0);
        chk({7'h00, irq_n}, 8'h00);
        e = '0;
        e.channel_off = 4'h2;
        pulse(e, '0);
        rd(CMD_DETECTION_EVENT_PEEK, READ_ZERO);
        chk({7'h00, irq_n}, 8'h01);
        $display("mask test done");
    endtask : t_mask
    task automatic t_det;
        channel_events_t e;
        e = '0;
        e.class_cycle = 4'h1;
        e.class_result_change = 4'h8;
        e.detect_cycle = 4'h1;
        e.detect_result_change = 4'h2;
        @(posedge clk);
        class_change_mode <= 1'b1;
        pulse(e, '0);
        rd(CMD_DETECTION_EVENT_CLEAR_READ, 8'h81);
        rd(CMD_DETECTION_EVENT_PEEK, READ_ZERO);
        @(posedge clk);
        class_change_mode <= 1'b0;
        detect_change_mode <= 1'b1;
        pulse(e, '0);
        rd(CMD_DETECTION_EVENT_CLEAR_READ, 8'h12);
        wr(CMD_INTERRUPT_MASK, MASK_RESET);
        wr(CMD_POWER_EVENT_PEEK, 8'hFF);
        e = '0;
        e.power_good_change = 4'h2;
        pulse(e, '{supply_fault: 1'b1, default: 1'b0});
        chk({7'h00, irq_n}, 8'h00);
        rd(CMD_INTERRUPT_SUMMARY, 8'h82);
        reset_summary();
        rd(CMD_INTERRUPT_SUMMARY, SUMMARY_RESET);
        chk({7'h00, irq_n}, 8'h01);
        $display("detection test done");
    endtask : t_det
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_power();
        t_mask();
        t_det();
        final_report();
    end
endmodule : tb_top
